// file: hdl/msrbte_map.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: Byte addressing on a 32-bit AXI4-Lite register bus
// Notes: Definitions only
`ifndef MSRBTE_MAP_SVH
`define MSRBTE_MAP_SVH

`define MSRBTE_ADDR_W 8
`define MSRBTE_CNT_W 20
`define MSRBTE_WIDE_W 32
`define MSRBTE_LEN_W 14
`define MSRBTE_NUM_BINS 7
`define MSRBTE_NUM_TXC 7

// Register byte offsets
`define MSRBTE_OFF_RX_BIN0 8'h00
`define MSRBTE_OFF_LPI_TRANS 8'h1c
`define MSRBTE_OFF_LPI_TIME 8'h20
`define MSRBTE_OFF_TX_CNT0 8'h24
`define MSRBTE_OFF_BAD_BYTES 8'h40
`define MSRBTE_OFF_CTRL 8'h44

// Control register fields
`define MSRBTE_CTL_EEE_BIT 0
`define MSRBTE_CTL_FPF_BIT 1
`define MSRBTE_CTL_FORCE_BAD_FCS_CTL_BIT 2
`define MSRBTE_CTL_MAX_LSB 16
`define MSRBTE_CTL_MAX_RST 14'h05ee

// Receive length bin bounds, bytes
`define MSRBTE_LEN_64 14'h0040
`define MSRBTE_LEN_127 14'h007f
`define MSRBTE_LEN_255 14'h00ff
`define MSRBTE_LEN_511 14'h01ff
`define MSRBTE_LEN_1023 14'h03ff
`define MSRBTE_LEN_1518 14'h05ee

// Transmit counter indices
`define MSRBTE_TX_FCS 0
`define MSRBTE_TX_DEFER 1
`define MSRBTE_TX_CARRIER 2
`define MSRBTE_TX_SINGLE 3
`define MSRBTE_TX_MULTI 4
`define MSRBTE_TX_EXCESS 5
`define MSRBTE_TX_LATE 6

`define MSRBTE_COLL_LIMIT 5'h10
`define MSRBTE_DEFER_MARGIN 16'h0010

// Microsecond time base
`define MSRBTE_CLK_PERIOD_PS 5000
`define MSRBTE_US_PS 1000000
`define MSRBTE_CYC_PER_US (`MSRBTE_US_PS / `MSRBTE_CLK_PERIOD_PS)

`define MSRBTE_RESP_OKAY 2'h0
`define MSRBTE_RESP_SLVERR 2'h2

`endif

// file: hdl/msrbte_pkg.sv
// Purpose: Types for the statistics counter block
// Assumes: Map header supplies widths
// Notes: Whole block state is one packed struct
`include "msrbte_map.svh"

package msrbte_pkg;

  typedef logic [`MSRBTE_CNT_W-1:0] msrbte_cnt_type;
  typedef logic [`MSRBTE_WIDE_W-1:0] msrbte_wide_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_held;
    logic [`MSRBTE_ADDR_W-1:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic eee_en;
    logic fwd_pause;
    logic force_fcs;
    logic [`MSRBTE_LEN_W-1:0] max_size;
    logic lpi_prev;
    logic [7:0] us_pre;
    msrbte_wide_type lpi_trans;
    msrbte_wide_type lpi_time;
    msrbte_wide_type bad_bytes;
    msrbte_cnt_type [`MSRBTE_NUM_BINS-1:0] rx_bin;
    msrbte_cnt_type [`MSRBTE_NUM_TXC-1:0] tx_cnt;
    logic [4:0] col_cnt;
    logic abort_pulse;
    logic [15:0] defer_timer;
    logic defer_flag;
  } msrbte_state_type;

endpackage : msrbte_pkg

// file: hdl/msrbte_top.sv
// Purpose: Receive length bins, receive LPI and transmit error statistics
// Assumes: All inputs synchronous to aclk; event inputs are 1-cycle pulses
// Notes: Registers on AXI4-Lite; counters are read-only and wrap
//
// Functional notes
// R01 - Count good received frames of exactly 64 bytes, 20 bits.
// R02 - Count good received frames per range 65-127 up to 1024-1518, once each.
// R03 - Count good received frames longer than 1518 bytes, 20 bits.
// R04 - Address-filter rejects and FIFO-overflow drops never reach a length bin.
// R05 - The 64-byte bin also skips pause frames removed by the pause filter.
// R06 - Count rising edges of PHY low-power-idle indication, 32 bits.
// R07 - Accumulate microseconds of PHY low-power-idle indication, 32 bits.
// R08 - Both LPI counters held clear while EEE enable is low.
// R09 - LPI counters keep running in low-power states zero, three, normal.
// R10 - Count bad-FCS transmit frames; force control makes transmitter corrupt FCS.
// R11 - Count frames deferred beyond twice max frame size plus 16 bytes.
// R12 - Deferral timer restarts from zero on every new deferral period.
// R13 - Count transmit frames with carrier sense error, 20 bits.
// R14 - Accumulate bytes sent by errored transmissions, 32 bits.
// R15 - Count frames sent successfully after exactly one collision.
// R16 - Count frames sent successfully after more than one collision.
// R17 - Abort a frame at 16 collisions and count it as excessive.
// R18 - Count transmit frames aborted by a late collision.
// R19 - All counters wrap at full scale and clear on reset.
//
// Local design decisions: the address map and register access over AXI4-Lite.
`include "msrbte_map.svh"
`timescale 1ns/1ps
`default_nettype none

module msrbte_top #(
  parameter int CYC_PER_US = `MSRBTE_CYC_PER_US
) (
  input wire logic aclk, // Block clock, 200 MHz
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [`MSRBTE_ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [`MSRBTE_ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic rx_frame_done, // Pulse: receive frame finished
  input wire logic [`MSRBTE_LEN_W-1:0] rx_frame_len, // Frame length, bytes
  input wire logic rx_frame_err, // Frame had a receive error
  input wire logic rx_addr_fail, // Frame failed address filtering
  input wire logic rx_fifo_drop, // Frame dropped on FIFO overflow
  input wire logic rx_pause_frame, // Frame is a pause frame
  input wire logic phy_rx_lpi, // Level: PHY indicates LPI
  input wire logic tx_frame_done, // Pulse: transmit attempt finished
  input wire logic tx_frame_ok, // Frame sent successfully
  input wire logic tx_fcs_bad, // Frame sent with bad FCS
  input wire logic tx_carrier_err, // No carrier or carrier lost
  input wire logic tx_late_col, // Aborted on late collision
  input wire logic tx_frame_error, // Transmission ended in error
  input wire logic [`MSRBTE_LEN_W-1:0] tx_bytes_sent, // Bytes sent
  input wire logic tx_collision, // Pulse: one collision seen
  input wire logic tx_deferring, // Level: transmitter is deferring
  input wire logic tx_byte_tick, // Pulse: one byte time elapsed
  output logic force_bad_fcs_ctl, // Level: corrupt FCS on transmit
  output logic tx_abort_excess_col // Pulse: abort frame, 16 collisions
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  msrbte_pkg::msrbte_state_type st;
  msrbte_pkg::msrbte_state_type next_st;

  localparam logic [7:0] US_LAST = 8'(CYC_PER_US - 1);

  function automatic logic [31:0] read_mux(
    input msrbte_pkg::msrbte_state_type s,
    input logic [`MSRBTE_ADDR_W-1:0] a
  );
    logic [31:0] v;
    logic [`MSRBTE_ADDR_W-1:0] rel;
    v = 32'h0000_0000;
    rel = '0;
    if (a < `MSRBTE_OFF_LPI_TRANS) begin
      rel = (a - `MSRBTE_OFF_RX_BIN0) >> 2;
      v = {12'h000, s.rx_bin[rel[2:0]]};
    end else if (a == `MSRBTE_OFF_LPI_TRANS) begin
      v = s.lpi_trans;
    end else if (a == `MSRBTE_OFF_LPI_TIME) begin
      v = s.lpi_time;
    end else if (a < `MSRBTE_OFF_BAD_BYTES) begin
      rel = (a - `MSRBTE_OFF_TX_CNT0) >> 2;
      v = {12'h000, s.tx_cnt[rel[2:0]]};
    end else if (a == `MSRBTE_OFF_BAD_BYTES) begin
      v = s.bad_bytes;
    end else if (a == `MSRBTE_OFF_CTRL) begin
      v[`MSRBTE_CTL_EEE_BIT] = s.eee_en;
      v[`MSRBTE_CTL_FPF_BIT] = s.fwd_pause;
      v[`MSRBTE_CTL_FORCE_BAD_FCS_CTL_BIT] = s.force_fcs;
      v[`MSRBTE_CTL_MAX_LSB +: `MSRBTE_LEN_W] = s.max_size;
    end
    return v;
  endfunction : read_mux

  function automatic logic addr_mapped(input logic [`MSRBTE_ADDR_W-1:0] a);
    return (a[1:0] == 2'h0) && (a <= `MSRBTE_OFF_CTRL);
  endfunction : addr_mapped

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic rx_good;
    logic [15:0] defer_limit;
    logic [4:0] col_next;
    logic frame_defer;
    next_st = st;
    rx_good = 1'b0;
    defer_limit = 16'h0000;
    col_next = 5'h00;
    frame_defer = 1'b0;
    next_st.abort_pulse = 1'b0;

    // Register write: both halves may arrive in either order
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_held = 1'b1;
      next_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_held = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.aw_held && st.w_held && !st.bvalid) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = addr_mapped(st.awaddr) ? `MSRBTE_RESP_OKAY
                                              : `MSRBTE_RESP_SLVERR;
      // Counters are read-only; only the control word takes writes
      if (st.awaddr == `MSRBTE_OFF_CTRL) begin
        if (st.wstrb[0]) begin
          next_st.eee_en = st.wdata[`MSRBTE_CTL_EEE_BIT];
          next_st.fwd_pause = st.wdata[`MSRBTE_CTL_FPF_BIT];
          next_st.force_fcs = st.wdata[`MSRBTE_CTL_FORCE_BAD_FCS_CTL_BIT];
        end
        if (st.wstrb[2]) begin
          next_st.max_size[7:0] = st.wdata[23:16];
        end
        if (st.wstrb[3]) begin
          next_st.max_size[13:8] = st.wdata[29:24];
        end
      end
    end

    // Register read, data sampled from the current counters
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st.arready) begin
      next_st.rvalid = 1'b1;
      // Refused addresses return zero rather than a neighbouring counter
      next_st.rdata = addr_mapped(s_axi_araddr) ? read_mux(st, s_axi_araddr)
                                                 : 32'h0000_0000;
      next_st.rresp = addr_mapped(s_axi_araddr) ? `MSRBTE_RESP_OKAY
                                                 : `MSRBTE_RESP_SLVERR;
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive length bins

    rx_good = rx_frame_done && !rx_frame_err && !rx_addr_fail &&
              !rx_fifo_drop; // [R04]
    if (rx_good) begin
      if (rx_frame_len == `MSRBTE_LEN_64) begin
        // Pause frames the filter swallowed never reach software
        if (!(rx_pause_frame && !st.fwd_pause)) begin // [R05]
          next_st.rx_bin[0] = st.rx_bin[0] + 20'h00001; // [R01] [R19]
        end
      end else if (rx_frame_len > `MSRBTE_LEN_64 &&
                   rx_frame_len <= `MSRBTE_LEN_127) begin
        next_st.rx_bin[1] = st.rx_bin[1] + 20'h00001; // [R02]
      end else if (rx_frame_len > `MSRBTE_LEN_127 &&
                   rx_frame_len <= `MSRBTE_LEN_255) begin
        next_st.rx_bin[2] = st.rx_bin[2] + 20'h00001; // [R02]
      end else if (rx_frame_len > `MSRBTE_LEN_255 &&
                   rx_frame_len <= `MSRBTE_LEN_511) begin
        next_st.rx_bin[3] = st.rx_bin[3] + 20'h00001; // [R02]
      end else if (rx_frame_len > `MSRBTE_LEN_511 &&
                   rx_frame_len <= `MSRBTE_LEN_1023) begin
        next_st.rx_bin[4] = st.rx_bin[4] + 20'h00001; // [R02]
      end else if (rx_frame_len > `MSRBTE_LEN_1023 &&
                   rx_frame_len <= `MSRBTE_LEN_1518) begin
        next_st.rx_bin[5] = st.rx_bin[5] + 20'h00001; // [R02]
      end else if (rx_frame_len > `MSRBTE_LEN_1518) begin
        next_st.rx_bin[6] = st.rx_bin[6] + 20'h00001; // [R03]
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive LPI; no power-state gating so low-power states keep counting

    next_st.lpi_prev = phy_rx_lpi;
    if (!st.eee_en) begin
      next_st.lpi_trans = 32'h0000_0000; // [R08]
      next_st.lpi_time = 32'h0000_0000; // [R08]
      next_st.us_pre = 8'h00; // [R08]
    end else begin
      if (phy_rx_lpi && !st.lpi_prev) begin
        next_st.lpi_trans = st.lpi_trans + 32'h0000_0001; // [R06] [R09]
      end
      // Prescaler keeps partial microseconds across LPI gaps
      if (phy_rx_lpi) begin
        if (st.us_pre == US_LAST) begin
          next_st.us_pre = 8'h00;
          next_st.lpi_time = st.lpi_time + 32'h0000_0001; // [R07] [R09]
        end else begin
          next_st.us_pre = st.us_pre + 8'h01; // [R07]
        end
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit deferral

    defer_limit = {1'b0, st.max_size, 1'b0} + `MSRBTE_DEFER_MARGIN; // [R11]
    if (!tx_deferring) begin
      next_st.defer_timer = 16'h0000; // [R12]
    end else if (tx_byte_tick && st.defer_timer != 16'hffff) begin
      next_st.defer_timer = st.defer_timer + 16'h0001; // [R11]
    end
    if (st.defer_timer > defer_limit) begin
      next_st.defer_flag = 1'b1; // [R11]
    end
    frame_defer = st.defer_flag || (st.defer_timer > defer_limit);

    ////////////////////////////////////////////////////////////////////////
    // Transmit collisions and frame outcome

    col_next = st.col_cnt + 5'h01;
    if (tx_collision) begin
      if (col_next == `MSRBTE_COLL_LIMIT) begin
        next_st.col_cnt = 5'h00;
        next_st.abort_pulse = 1'b1; // [R17]
        next_st.defer_flag = 1'b0;
        next_st.tx_cnt[`MSRBTE_TX_EXCESS] =
          st.tx_cnt[`MSRBTE_TX_EXCESS] + 20'h00001; // [R17] [R19]
        if (frame_defer) begin
          next_st.tx_cnt[`MSRBTE_TX_DEFER] =
            st.tx_cnt[`MSRBTE_TX_DEFER] + 20'h00001; // [R11]
        end
      end else begin
        next_st.col_cnt = col_next;
      end
    end else if (tx_frame_done) begin
      next_st.col_cnt = 5'h00;
      next_st.defer_flag = 1'b0;
      if (frame_defer) begin
        next_st.tx_cnt[`MSRBTE_TX_DEFER] =
          st.tx_cnt[`MSRBTE_TX_DEFER] + 20'h00001; // [R11]
      end
      if (tx_fcs_bad) begin
        next_st.tx_cnt[`MSRBTE_TX_FCS] =
          st.tx_cnt[`MSRBTE_TX_FCS] + 20'h00001; // [R10]
      end
      if (tx_carrier_err) begin
        next_st.tx_cnt[`MSRBTE_TX_CARRIER] =
          st.tx_cnt[`MSRBTE_TX_CARRIER] + 20'h00001; // [R13]
      end
      if (tx_late_col) begin
        next_st.tx_cnt[`MSRBTE_TX_LATE] =
          st.tx_cnt[`MSRBTE_TX_LATE] + 20'h00001; // [R18]
      end
      if (tx_frame_error) begin
        next_st.bad_bytes = st.bad_bytes +
                            {18'h00000, tx_bytes_sent}; // [R14] [R19]
      end
      if (tx_frame_ok && st.col_cnt == 5'h01) begin
        next_st.tx_cnt[`MSRBTE_TX_SINGLE] =
          st.tx_cnt[`MSRBTE_TX_SINGLE] + 20'h00001; // [R15]
      end
      if (tx_frame_ok && st.col_cnt > 5'h01) begin
        next_st.tx_cnt[`MSRBTE_TX_MULTI] =
          st.tx_cnt[`MSRBTE_TX_MULTI] + 20'h00001; // [R16]
      end
    end

    // Write ready levels follow the held flags and read ready follows rvalid, so nothing is taken twice
    next_st.awready = !next_st.aw_held && !next_st.bvalid;
    next_st.wready = !next_st.w_held && !next_st.bvalid;
    next_st.arready = !next_st.rvalid;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0; // [R19]
      st.max_size <= `MSRBTE_CTL_MAX_RST;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign force_bad_fcs_ctl = st.force_fcs; // [R10]
  assign tx_abort_excess_col = st.abort_pulse; // [R17]

endmodule : msrbte_top

`default_nettype wire

// file: verification/msrbte_mac_model.sv
// Purpose: MAC datapath and PHY idle stand-in driving event inputs
// Assumes: Qualifiers matter only in their pulse cycle
// Notes: Qualifiers invert outside pulses so stale values never help
`timescale 1ns/1ps
`default_nettype none
module msrbte_mac_model (
  input wire logic aclk, // Clock
  output logic rx_frame_done, // Receive done
  output logic [13:0] rx_frame_len, // Bytes
  output logic rx_frame_err, // Error
  output logic rx_addr_fail, // Filtered
  output logic rx_fifo_drop, // Dropped
  output logic rx_pause_frame, // Pause
  output logic phy_rx_lpi, // Idle level
  output logic tx_frame_done, // Transmit done
  output logic tx_frame_ok, // Success
  output logic tx_fcs_bad, // Bad FCS
  output logic tx_carrier_err, // Carrier
  output logic tx_late_col, // Late
  output logic tx_frame_error, // Error
  output logic [13:0] tx_bytes_sent, // Bytes
  output logic tx_collision, // Collision
  output logic tx_deferring, // Deferring
  output logic tx_byte_tick // Byte time
);
  initial begin
    {rx_frame_done, rx_frame_err, rx_addr_fail, rx_fifo_drop} = 4'h0;
    {rx_pause_frame, phy_rx_lpi, tx_frame_done, tx_frame_ok} = 4'h0;
    {tx_fcs_bad, tx_carrier_err, tx_late_col, tx_frame_error} = 4'h0;
    {tx_collision, tx_deferring, tx_byte_tick} = 3'h0;
    rx_frame_len = 14'h0;
    tx_bytes_sent = 14'h0;
  end
  ////////////////////////////////////////////////////////////
  // f: pause, drop, filtered, error
  task automatic rx(input logic [13:0] n, input logic [3:0] f);
    @(posedge aclk);
    rx_frame_done <= 1'b1;
    rx_frame_len <= n;
    {rx_pause_frame, rx_fifo_drop, rx_addr_fail, rx_frame_err} <= f;
    @(posedge aclk);
    rx_frame_done <= 1'b0;
    rx_frame_len <= ~n;
    {rx_pause_frame, rx_fifo_drop, rx_addr_fail, rx_frame_err} <= ~f;
  endtask : rx
  // f: ok, bad FCS, carrier, late, error
  task automatic tx(input logic [4:0] f, input logic [13:0] n);
    @(posedge aclk);
    tx_frame_done <= 1'b1;
    tx_bytes_sent <= n;
    {tx_frame_ok, tx_fcs_bad, tx_carrier_err, tx_late_col} <= f[4:1];
    tx_frame_error <= f[0];
    @(posedge aclk);
    tx_frame_done <= 1'b0;
    tx_bytes_sent <= ~n;
    {tx_frame_ok, tx_fcs_bad, tx_carrier_err, tx_late_col} <= ~f[4:1];
    tx_frame_error <= ~f[0];
  endtask : tx
  task automatic col(input int n);
    repeat (n) begin
      @(posedge aclk);
      tx_collision <= 1'b1;
      @(posedge aclk);
      tx_collision <= 1'b0;
    end
  endtask : col
  task automatic defer(input int n);
    @(posedge aclk);
    tx_deferring <= 1'b1;
    repeat (n) begin
      @(posedge aclk);
      tx_byte_tick <= 1'b1;
      @(posedge aclk);
      tx_byte_tick <= 1'b0;
    end
    @(posedge aclk);
    tx_deferring <= 1'b0;
  endtask : defer
  task automatic lpi(input int n);
    @(posedge aclk);
    phy_rx_lpi <= 1'b1;
    repeat (n) @(posedge aclk);
    phy_rx_lpi <= 1'b0;
  endtask : lpi
endmodule : msrbte_mac_model
`default_nettype wire

// file: verification/msrbte_properties.sv
// Purpose: Port-level checks for the statistics counter block
// Assumes: One clock domain, synchronous active-low reset
// Notes: Counter values themselves are checked by bench reads
`include "msrbte_map.svh"
`timescale 1ns/1ps
`default_nettype none
module msrbte_properties #(
  parameter int CYC_PER_US = 200
) (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, active low
  input wire logic [`MSRBTE_ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  input wire logic s_axi_arready, // Read address ready
  input wire logic [31:0] s_axi_rdata, // Read data
  input wire logic [1:0] s_axi_rresp, // Read response
  input wire logic s_axi_rvalid, // Read valid
  input wire logic s_axi_rready, // Read ready
  input wire logic [1:0] s_axi_bresp, // Write response
  input wire logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic tx_collision, // Collision pulse
  input wire logic tx_frame_done, // Transmit done pulse
  input wire logic force_bad_fcs_ctl, // Force bad FCS level
  input wire logic tx_abort_excess_col // Excess abort pulse
);
  logic [4:0] col_n;
  logic ar_go;
  logic ar_bad;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////
  // Own tally; frame done is ignored in a collision cycle
  always_ff @(posedge aclk) begin
    if (!aresetn || (tx_collision && col_n == 5'h0f)) begin
      col_n <= 5'h00;
    end else if (tx_collision) begin
      col_n <= col_n + 5'h01;
    end else if (tx_frame_done) begin
      col_n <= 5'h00;
    end
  end
  assign ar_go = s_axi_arvalid && s_axi_arready;
  assign ar_bad = s_axi_araddr > 8'h44 || s_axi_araddr[1:0] != 2'h0;
  chk_abort_sixteen: assert property (
    tx_collision && col_n == 5'h0f |=> tx_abort_excess_col)
    else $error("abort missing after collision limit");
  chk_abort_cause: assert property (
    tx_abort_excess_col |-> $past(tx_collision) && $past(col_n) == 5'h0f)
    else $error("abort without collision limit");
  chk_abort_single: assert property (
    tx_abort_excess_col |=> !tx_abort_excess_col)
    else $error("abort pulse too long");
  chk_fcs_on_write: assert property (
    $changed(force_bad_fcs_ctl) |-> $rose(s_axi_bvalid))
    else $error("force control moved without a write");
  chk_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read response dropped early");
  chk_read_answer: assert property (
    ar_go |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered next cycle");
  chk_unmapped_err: assert property (ar_go && ar_bad |=>
    s_axi_rresp == `MSRBTE_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  chk_mapped_okay: assert property (
    ar_go && !ar_bad |=> s_axi_rresp == `MSRBTE_RESP_OKAY)
    else $error("mapped read refused");
  cov_abort: cover property (tx_abort_excess_col);
  cov_slverr: cover property (ar_go && ar_bad);
  cov_force: cover property ($rose(force_bad_fcs_ctl));
endmodule : msrbte_properties
bind msrbte_top msrbte_properties #(.CYC_PER_US(CYC_PER_US)) u_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .tx_collision(tx_collision),
  .tx_frame_done(tx_frame_done), .force_bad_fcs_ctl(force_bad_fcs_ctl),
  .tx_abort_excess_col(tx_abort_excess_col));
`default_nettype wire

// file: verification/msrbte_top_tb.sv
// Purpose: Self-checking bench for the statistics counter block
// Assumes: Microsecond prescale shortened to 4 cycles
// Notes: Counters are seen only through register reads
`timescale 1ns/1ps
`default_nettype none
module msrbte_top_tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic rx_frame_done, rx_frame_err, rx_addr_fail, rx_fifo_drop;
  logic rx_pause_frame, phy_rx_lpi, tx_frame_done, tx_frame_ok;
  logic tx_fcs_bad, tx_carrier_err, tx_late_col, tx_frame_error;
  logic tx_collision, tx_deferring, tx_byte_tick;
  logic force_bad_fcs_ctl, tx_abort_excess_col;
  logic [13:0] rx_frame_len, tx_bytes_sent;
  int fail_count = 0;
  int compares = 0;
  logic [13:0] lens [13] = '{14'h3f, 14'h40, 14'h41, 14'h7f, 14'h80,
    14'hff, 14'h100, 14'h1ff, 14'h200, 14'h3ff, 14'h400, 14'h5ee, 14'h5ef};
  logic [31:0] rx_exp [7] = '{32'h2, 32'h2, 32'h2, 32'h2, 32'h2, 32'h2, 32'h1};
  logic [31:0] tx_exp [7] = '{32'h1, 32'h1, 32'h1, 32'h2, 32'h1, 32'h1, 32'h1};
  msrbte_top #(.CYC_PER_US(4)) dut (.*);
  msrbte_mac_model mac (.*);
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Ready is raised late on purpose so responses must wait
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_done;
    logic w_done;
    {aw_done, w_done} = 2'b00;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    repeat (2) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'h0, {30'h0, s_axi_bresp});
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk($sformatf("rdata %h", a), e, s_axi_rdata);
    chk($sformatf("rresp %h", a), {30'h0, er}, {30'h0, s_axi_rresp});
  endtask : rdc
  task automatic results();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    results();
  end
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    aresetn = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(8'h44, 32'h05ee0000, 2'h0);
    rdc(8'h48, 32'h0, 2'h2);
    rdc(8'h06, 32'h0, 2'h2);
    wr(8'h00, 32'hffffffff);
    rdc(8'h00, 32'h0, 2'h0);
    $display("test registers done");
    foreach (lens[i]) mac.rx(lens[i], 4'h0);
    mac.rx(14'h64, 4'h1);
    mac.rx(14'h64, 4'h2);
    mac.rx(14'h64, 4'h4);
    mac.rx(14'h40, 4'h8);
    wr(8'h44, 32'h05ee0002);
    mac.rx(14'h40, 4'h8);
    for (int i = 0; i < 7; i++) rdc(8'(4 * i), rx_exp[i], 2'h0);
    rdc(8'h05, 32'h0, 2'h2);
    $display("test receive bins done");
    mac.lpi(5);
    rdc(8'h1c, 32'h0, 2'h0);
    wr(8'h44, 32'h05ee0001);
    mac.lpi(10);
    mac.lpi(6);
    rdc(8'h1c, 32'h2, 2'h0);
    rdc(8'h20, 32'h4, 2'h0);
    wr(8'h44, 32'h05ee0000);
    rdc(8'h1c, 32'h0, 2'h0);
    rdc(8'h20, 32'h0, 2'h0);
    $display("test idle counters done");
    s_axi_wstrb <= 4'h1;
    wr(8'h44, 32'h3fff0004);
    rdc(8'h44, 32'h05ee0004, 2'h0);
    s_axi_wstrb <= 4'hc;
    wr(8'h44, 32'h000a0000);
    s_axi_wstrb <= 4'hf;
    chk("force", 32'h1, {31'h0, force_bad_fcs_ctl});
    mac.col(1);
    mac.tx(5'h10, 14'h0);
    mac.col(3);
    mac.tx(5'h10, 14'h0);
    mac.tx(5'h09, 14'h3c);
    mac.tx(5'h05, 14'h28);
    mac.tx(5'h03, 14'h1e);
    mac.col(16);
    mac.col(1);
    mac.tx(5'h10, 14'h0);
    mac.defer(36);
    mac.tx(5'h10, 14'h0);
    mac.defer(30);
    mac.defer(30);
    mac.tx(5'h10, 14'h0);
    mac.defer(37);
    mac.tx(5'h10, 14'h0);
    for (int i = 0; i < 7; i++) rdc(8'(36 + 4 * i), tx_exp[i], 2'h0);
    rdc(8'h40, 32'h82, 2'h0);
    wr(8'h44, 32'h0);
    chk("force", 32'h0, {31'h0, force_bad_fcs_ctl});
    $display("test transmit errors done");
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(8'h40, 32'h0, 2'h0);
    rdc(8'h44, 32'h05ee0000, 2'h0);
    $display("test reset done");
    results();
  end
endmodule : msrbte_top_tb
`default_nettype wire
